// file: src/vch_device_port.sv
`include "vch_map.svh"
module vch_device_port (
    input  wire logic                 clk,
    input  wire logic                 resetn,
    vch_link_if.device                link,
    input  wire vch_pkg::vch_chan_t   chanBusy,
    input  wire vch_pkg::vch_chan_t   chanReady,
    input  wire vch_pkg::vch_addr_t   fetchAddr,
    input  wire logic                 fetchEnable,
    input  wire logic [3:0]           factoryPins,
    output logic                      wordValid,
    output vch_pkg::vch_byte_t        wordData,
    output logic                      wordIsSub,
    output vch_pkg::vch_byte_t        romByte,
    output logic                      leftAudioOut,
    output logic                      rightAudioOut
);
    // two-flop synchronisers for all pins from outside
    logic [7:0]         busS1_q;
    logic [7:0]         busS2_q;
    logic [5:0]         ctlS1_q;
    logic [5:0]         ctlS2_q;
    logic [7:0]         romS1_q;
    logic [7:0]         romS2_q;
    logic               memS1_q;
    logic               memS2_q;
    logic [3:0]         facS1_q;
    logic [3:0]         facS2_q;
    // edge detectors on the synchronised strobes
    logic               sckPrev_q;
    logic               wrPrev_q;
    logic               sckRise;
    logic               sckFall;
    logic               wrRise;
    // synchronised control levels
    logic               sck;
    logic               wrN;
    logic               rdN;
    logic               csN;
    logic               cmdSel;
    logic               serialSel;
    logic               kindSel;
    logic               memSelN;
    logic               factoryAny;
    // captured word, serial shifter and status shifter
    logic [7:0]         shift_q;
    logic [7:0]         shift_d;
    logic [7:0]         word_q;
    logic [7:0]         word_d;
    logic [7:0]         sout_q;
    logic [7:0]         sout_d;
    logic [2:0]         bits_q;
    logic [2:0]         bits_d;
    logic               valid_q;
    logic               valid_d;
    logic               sub_q;
    logic               sub_d;
    vch_pkg::vch_chan_t status;

    // one serial step: shift left, new bit enters at the bottom
    function automatic vch_pkg::vch_byte_t shiftIn(
        input vch_pkg::vch_byte_t cur,
        input logic               bitIn
    );
        return {cur[6:0], bitIn};
    endfunction : shiftIn

    // synchroniser chain, first stage read only by second
    always_ff @(posedge clk) begin
        busS1_q   <= link.busIn;
        busS2_q   <= busS1_q;
        ctlS1_q   <= {link.csN, link.wrN, link.rdN, link.cmdSel,
                      link.serialSel, link.statusKindSel};
        ctlS2_q   <= ctlS1_q;
        romS1_q   <= link.romData;
        romS2_q   <= romS1_q;
        memS1_q   <= link.memoryPortSelectN;
        memS2_q   <= memS1_q;
        facS1_q   <= factoryPins;
        facS2_q   <= facS1_q;
        sckPrev_q <= sck;
        wrPrev_q  <= wrN;
    end

    assign {csN, wrN, rdN, cmdSel, serialSel, kindSel} = ctlS2_q;
    // memory select pin, seen two cycles late through its flops
    assign memSelN    = memS2_q;
    assign factoryAny = |facS2_q;
    assign sck     = busS2_q[`VCH_SER_CLK_BIT];
    assign sckRise = sck && !sckPrev_q;
    assign sckFall = !sck && sckPrev_q;
    assign wrRise  = wrN && !wrPrev_q;

    assign status = kindSel ? chanReady : chanBusy;

    // capture logic next values
    always_comb begin
        shift_d = shift_q;
        bits_d  = bits_q;
        word_d  = word_q;
        sub_d   = sub_q;
        valid_d = 1'b0;
        sout_d  = sout_q;
        if (serialSel) begin
            if (csN) begin
                // a partial word is dropped when chip select rises
                bits_d = 3'h0;
                // status reloaded while the host is idle
                sout_d = {4'h0, status};
            end else if (sckRise) begin
                shift_d = shiftIn(shift_q, busS2_q[`VCH_SER_DATA_BIT]);
                bits_d  = bits_q + 3'h1;
                if (bits_q == 3'(`VCH_SER_BITS - 1)) begin
                    word_d  = shiftIn(shift_q, busS2_q[`VCH_SER_DATA_BIT]);
                    sub_d   = cmdSel;
                    valid_d = 1'b1;
                end
            end else if (sckFall) begin
                sout_d = {sout_q[6:0], 1'b0};
            end
        end else begin
            if (wrRise && !csN) begin
                word_d  = busS2_q;
                sub_d   = cmdSel;
                valid_d = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            shift_q <= `VCH_RESET_DATA;
            word_q  <= `VCH_RESET_DATA;
            sout_q  <= `VCH_RESET_DATA;
            bits_q  <= 3'h0;
            sub_q   <= 1'b0;
            valid_q <= 1'b0;
        end else begin
            shift_q <= shift_d;
            word_q  <= word_d;
            sout_q  <= sout_d;
            bits_q  <= bits_d;
            sub_q   <= sub_d;
            valid_q <= valid_d;
        end
    end

    // bus drivers per mode
    always_comb begin
        link.devBusOut = 8'h00;
        link.devBusOe  = 8'h00;
        if (!resetn) begin
            link.devBusOe = 8'h00;
        end else if (serialSel) begin
            link.devBusOut[3:0] = status;
            link.devBusOe[3:0]  = 4'hf;
            link.devBusOut[`VCH_SER_OUT_BIT] = sout_q[3];
            link.devBusOe[`VCH_SER_OUT_BIT]  = 1'b1;
        end else if (!rdN) begin
            link.devBusOut = {4'h0, status};
            link.devBusOe  = 8'hff;
        end
    end

    // memory pins floated on select high
    assign link.romAddress        = fetchAddr;
    assign link.romAddressOe      = memSelN ? 24'h00_0000 : 24'hff_ffff;
    assign link.romOutputEnable   = fetchEnable;
    assign link.romOutputEnableOe = !memSelN;

    assign wordValid = valid_q;
    assign wordData  = word_q;
    assign wordIsSub = sub_q;
    assign romByte   = romS2_q;
    // audio held at ground in and out of reset
    assign leftAudioOut  = 1'b0 & factoryAny;
    assign rightAudioOut = 1'b0 & factoryAny;
endmodule : vch_device_port

// file: src/vch_host_port.sv
`include "vch_map.svh"
module vch_host_port (
    input  wire logic                 clk,
    input  wire logic                 resetn,
    vch_link_if.host                  link,
    input  wire logic                 useSerial,
    input  wire logic                 kindReady,
    input  wire logic                 memSelectN,
    input  wire logic                 reqWrite,
    input  wire logic                 reqRead,
    input  wire logic                 reqSub,
    input  wire vch_pkg::vch_byte_t   reqData,
    output logic                      reqReady,
    output logic                      rspValid,
    output vch_pkg::vch_chan_t        rspStatus
);
    vch_pkg::vch_host_st_t st_q, st_d;
    logic [7:0] data_q, data_d, in1_q, in2_q;
    logic [4:0] div_q, div_d;
    logic [3:0] bits_q, bits_d;
    logic       sck_q, sck_d, sub_q, sub_d, valid_q, valid_d;
    logic [3:0] stat_q, stat_d;

    // bus input synchroniser
    always_ff @(posedge clk) begin
        in1_q <= link.busIn;
        in2_q <= in1_q;
    end

    // host sequencer next values
    always_comb begin
        st_d    = st_q;
        data_d  = data_q;
        div_d   = div_q;
        bits_d  = bits_q;
        sck_d   = sck_q;
        sub_d   = sub_q;
        valid_d = 1'b0;
        stat_d  = stat_q;
        unique case (st_q)
            vch_pkg::HST_IDLE: begin
                div_d  = 5'h00;
                bits_d = 4'h0;
                sck_d  = 1'b0;
                if (reqWrite) begin
                    data_d = reqData;
                    sub_d  = reqSub;
                    st_d   = useSerial ? vch_pkg::HST_SHIFT
                                       : vch_pkg::HST_WRITE;
                end else if (reqRead && !useSerial) begin
                    st_d = vch_pkg::HST_READ;
                end
            end
            vch_pkg::HST_WRITE, vch_pkg::HST_READ: begin
                div_d = div_q + 5'h01;
                if (div_q == 5'(`VCH_STB_CYCLES + 2)) begin
                    stat_d  = in2_q[3:0];
                    valid_d = (st_q == vch_pkg::HST_READ);
                    st_d    = vch_pkg::HST_IDLE;
                end
            end
            vch_pkg::HST_SHIFT: begin
                div_d = div_q + 5'h01;
                if (div_q == 5'(`VCH_SCK_HALF - 1)) begin
                    div_d = 5'h00;
                    sck_d = !sck_q;
                    if (sck_q) begin
                        data_d = {data_q[6:0], 1'b0};
                        bits_d = bits_q + 4'h1;
                        if (bits_q == 4'(`VCH_SER_BITS - 1)) begin
                            stat_d  = in2_q[3:0];
                            valid_d = 1'b1;
                            st_d    = vch_pkg::HST_IDLE;
                        end
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            st_q    <= vch_pkg::HST_IDLE;
            data_q  <= 8'h00;
            div_q   <= 5'h00;
            bits_q  <= 4'h0;
            sck_q   <= 1'b0;
            sub_q   <= 1'b0;
            valid_q <= 1'b0;
            stat_q  <= 4'h0;
        end else begin
            st_q    <= st_d;
            data_q  <= data_d;
            div_q   <= div_d;
            bits_q  <= bits_d;
            sck_q   <= sck_d;
            sub_q   <= sub_d;
            valid_q <= valid_d;
            stat_q  <= stat_d;
        end
    end

    // pin drive: write strobe low for middle cycles, read strobe low from second cycle to end of access
    always_comb begin
        link.hostBusOut = 8'h00;
        link.hostBusOe  = 8'h00;
        link.wrN = 1'b1;
        link.rdN = 1'b1;
        link.csN = (st_q == vch_pkg::HST_IDLE);
        if (st_q == vch_pkg::HST_WRITE) begin
            link.hostBusOut = data_q;
            link.hostBusOe  = 8'hff;
            link.wrN = !(div_q >= 5'h01 && div_q <= 5'(`VCH_STB_CYCLES));
        end else if (st_q == vch_pkg::HST_READ) begin
            link.rdN = !(div_q >= 5'h01);
        end else if (st_q == vch_pkg::HST_SHIFT) begin
            // bit4 left undriven; board tie holds it low
            link.hostBusOut[7] = data_q[7];
            link.hostBusOut[6] = sck_q;
            link.hostBusOe[7:6] = 2'b11;
        end
    end

    assign link.cmdSel            = sub_q;
    assign link.serialSel         = useSerial;
    assign link.statusKindSel     = kindReady;
    assign link.memoryPortSelectN = memSelectN;
    assign reqReady  = (st_q == vch_pkg::HST_IDLE);
    assign rspValid  = valid_q;
    assign rspStatus = stat_q;
endmodule : vch_host_port

// file: src/vch_link_if.sv
`include "vch_map.svh"
interface vch_link_if;
    // bus lines, each end drives via enable
    logic [7:0]  hostBusOut;
    logic [7:0]  hostBusOe;
    logic [7:0]  devBusOut;
    logic [7:0]  devBusOe;
    logic [7:0]  busIn;
    logic        csN;
    logic        wrN;
    logic        rdN;
    logic        cmdSel;
    logic        serialSel;
    logic        statusKindSel;
    logic        memoryPortSelectN;
    logic [23:0] romAddress;
    logic [23:0] romAddressOe;
    logic        romOutputEnable;
    logic        romOutputEnableOe;
    logic [7:0]  romData;
    // resolved level: driven bit wins, else pulled low
    assign busIn = (hostBusOut & hostBusOe) | (devBusOut & devBusOe);
    modport device (
        input  busIn, csN, wrN, rdN, cmdSel, serialSel, statusKindSel,
        input  memoryPortSelectN, romData,
        output devBusOut, devBusOe, romAddress, romAddressOe,
        output romOutputEnable, romOutputEnableOe
    );
    modport host (
        input  busIn,
        output hostBusOut, hostBusOe, csN, wrN, rdN, cmdSel, serialSel,
        output statusKindSel, memoryPortSelectN
    );
endinterface : vch_link_if

// file: src/vch_map.svh
`ifndef VCH_MAP_SVH
`define VCH_MAP_SVH
// widths
`define VCH_ADDR_W      24
`define VCH_DATA_W      8
`define VCH_CHAN_N      4
// serial word layout
`define VCH_SER_BITS    8
`define VCH_SER_CNT_W   3
// bus bit positions used by the serial link
`define VCH_SER_DATA_BIT   7
`define VCH_SER_CLK_BIT    6
`define VCH_SER_OUT_BIT    5
`define VCH_SER_UNUSED_BIT 4
// host serial clock divider: half period in clk cycles
`define VCH_SCK_HALF    10
`define VCH_SCK_HALF_W  5
// parallel write strobe width in clk cycles
`define VCH_STB_CYCLES  4
// reset values
`define VCH_RESET_ADDR  24'h00_0000
`define VCH_RESET_DATA  8'h00
`endif

// file: src/vch_pkg.sv
package vch_pkg;
    typedef logic [7:0]  vch_byte_t;
    typedef logic [23:0] vch_addr_t;
    typedef logic [3:0]  vch_chan_t;
    // one-hot host states
    typedef enum logic [3:0] {
        HST_IDLE  = 4'b0001,
        HST_WRITE = 4'b0010,
        HST_READ  = 4'b0100,
        HST_SHIFT = 4'b1000
    } vch_host_st_t;
endpackage : vch_pkg

// file: test/vch_link_props.sv
module vch_link_props (
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic [7:0]  busIn,
    input wire logic [7:0]  hostBusOe,
    input wire logic [7:0]  devBusOe,
    input wire logic        csN,
    input wire logic        wrN,
    input wire logic        rdN,
    input wire logic        cmdSel,
    input wire logic        serialSel,
    input wire logic        memoryPortSelectN,
    input wire logic [23:0] romAddressOe,
    input wire logic        romOutputEnableOe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // memory pins follow the port select
    AST_ROM_DRIVEN: assert property ((!memoryPortSelectN)[*3] |->
        &romAddressOe && romOutputEnableOe) else $error("rom pins floated");
    AST_ROM_FLOAT: assert property (memoryPortSelectN[*3] |->
        romAddressOe == 24'h00_0000 && !romOutputEnableOe)
        else $error("rom pins driven");
    // write strobe only under chip select, bus and command select held
    AST_WR_CS: assert property (!wrN |-> !csN)
        else $error("write strobe without select");
    AST_WR_HOLD: assert property (!wrN && $past(!wrN) |->
        $stable(busIn) && $stable(cmdSel)) else $error("bus moved in write");
    // parallel read drives status, otherwise bus released
    AST_PAR_READ: assert property (!serialSel && !rdN ##1 !rdN ##1 !rdN
        |-> devBusOe[3:0] == 4'hf) else $error("status not driven");
    AST_PAR_QUIET: assert property ((!serialSel && rdN)[*3]
        |-> devBusOe == 8'h00) else $error("bus driven outside read");
    // serial pin directions
    AST_SER_PINS: assert property (serialSel[*3] |->
        devBusOe[7:6] == 2'b00 && !devBusOe[4] && !hostBusOe[4])
        else $error("serial input pin driven");
    AST_SER_STATUS: assert property ((serialSel && !csN)[*2] |->
        devBusOe[5] && devBusOe[3:0] == 4'hf) else $error("serial status off");
    AST_SCK_HALF: assert property (serialSel && $rose(busIn[6]) |=>
        $stable(busIn[6])[*8]) else $error("serial clock too fast");
endmodule : vch_link_props

// file: test/voice_chip_host_and_rom_port_tb.sv
module voice_chip_host_and_rom_port_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic               clk = 1'b0;
    logic               resetn = 1'b0;
    logic               useSerial = 1'b0;
    logic               kindReady = 1'b0;
    logic               memSelectN = 1'b1;
    logic               reqWrite = 1'b0;
    logic               reqRead = 1'b0;
    logic               reqSub = 1'b0;
    vch_pkg::vch_byte_t reqData = 8'h00;
    vch_pkg::vch_chan_t chanBusy = 4'h0;
    vch_pkg::vch_chan_t chanReady = 4'h0;
    vch_pkg::vch_addr_t fetchAddr = 24'h00_0000;
    logic               fetchEnable = 1'b0;
    logic               reqReady, rspValid, wordValid, wordIsSub;
    logic               leftAudioOut, rightAudioOut;
    vch_pkg::vch_chan_t rspStatus;
    vch_pkg::vch_byte_t wordData, romByte;
    int                 failCount = 0;
    int                 cmpCount = 0;
    int                 cycles = 0;
    vch_link_if link ();
    vch_host_port vch_host_port_inst (.clk(clk), .resetn(resetn), .link(link),
        .useSerial(useSerial), .kindReady(kindReady), .memSelectN(memSelectN),
        .reqWrite(reqWrite), .reqRead(reqRead), .reqSub(reqSub),
        .reqData(reqData), .reqReady(reqReady), .rspValid(rspValid),
        .rspStatus(rspStatus));
    vch_device_port vch_device_port_inst (.clk(clk), .resetn(resetn),
        .link(link), .chanBusy(chanBusy), .chanReady(chanReady),
        .fetchAddr(fetchAddr), .fetchEnable(fetchEnable),
        .factoryPins(4'h0), .wordValid(wordValid), .wordData(wordData),
        .wordIsSub(wordIsSub), .romByte(romByte),
        .leftAudioOut(leftAudioOut), .rightAudioOut(rightAudioOut));
    vch_link_props vch_link_props_inst (.clk(clk), .resetn(resetn),
        .busIn(link.busIn), .hostBusOe(link.hostBusOe),
        .devBusOe(link.devBusOe), .csN(link.csN), .wrN(link.wrN),
        .rdN(link.rdN), .cmdSel(link.cmdSel), .serialSel(link.serialSel),
        .memoryPortSelectN(link.memoryPortSelectN),
        .romAddressOe(link.romAddressOe),
        .romOutputEnableOe(link.romOutputEnableOe));
    // clock and hang guard
    always #4 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 4000) begin
            failCount++;
            wrapUp();
        end
    end
    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        cmpCount++;
        if (got !== exp) begin
            failCount++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : check
    // one host request, then wait for the matching answer
    task automatic request(input logic rd, input logic sub,
                           input vch_pkg::vch_byte_t data, input int lim);
        int n;
        n = 0;
        @(negedge clk);
        while (reqReady !== 1'b1 && n < lim) begin
            @(negedge clk);
            n++;
        end
        reqRead = rd;
        reqWrite = !rd;
        reqSub = sub;
        reqData = data;
        @(negedge clk);
        reqRead = 1'b0;
        reqWrite = 1'b0;
        while (!(rd ? rspValid === 1'b1 : wordValid === 1'b1) && n < lim) begin
            @(negedge clk);
            n++;
        end
        check(24'(n < lim), 24'h00_0001);
    endtask : request
    task automatic test_par_write();
        request(1'b0, 1'b0, 8'ha5, 60);
        check(24'(wordData), 24'h00_00a5);
        check(24'(wordIsSub), 24'h00_0000);
        request(1'b0, 1'b1, 8'h3c, 60);
        check(24'(wordData), 24'h00_003c);
        check(24'(wordIsSub), 24'h00_0001);
    endtask : test_par_write
    task automatic test_par_read();
        chanBusy = 4'h5;
        chanReady = 4'ha;
        for (int k = 0; k < 2; k++) begin
            kindReady = k[0];
            request(1'b1, 1'b0, 8'h00, 60);
            check(24'(rspStatus), k ? 24'h00_000a : 24'h00_0005);
        end
    endtask : test_par_read
    task automatic test_serial();
        useSerial = 1'b1;
        kindReady = 1'b0;
        chanBusy = 4'h9;
        repeat (3) @(negedge clk);
        check(24'(link.busIn[5]), 24'h00_0001);
        request(1'b0, 1'b1, 8'hc6, 600);
        check(24'(wordData), 24'h00_00c6);
        check(24'(wordIsSub), 24'h00_0001);
        check(24'(link.busIn[3:0]), 24'h00_0009);
        check(24'(link.busIn[4]), 24'h00_0000);
        check(24'(link.busIn[5]), 24'h00_0000);
        while (rspValid !== 1'b1) begin
            @(negedge clk);
        end
        check(24'(rspStatus), 24'h00_0009);
        useSerial = 1'b0;
    endtask : test_serial
    task automatic test_rom();
        memSelectN = 1'b0;
        fetchAddr = 24'h12_3456;
        fetchEnable = 1'b1;
        link.romData = 8'h5a;
        repeat (4) @(negedge clk);
        check(link.romAddressOe, 24'hff_ffff);
        check(link.romAddress, 24'h12_3456);
        check(24'(link.romOutputEnable), 24'h00_0001);
        check(24'(romByte), 24'h00_005a);
        memSelectN = 1'b1;
        repeat (3) @(negedge clk);
        check(link.romAddressOe, 24'h00_0000);
        check(24'(link.romOutputEnableOe), 24'h00_0000);
    endtask : test_rom
    task automatic wrapUp();
        $display("compares %0d mismatches %0d", cmpCount, failCount);
        if (failCount == 0 && cmpCount > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : wrapUp
    // reset, quiet outputs, then the scenarios
    initial begin
        link.romData = 8'h00;
        repeat (2) @(negedge clk);
        check(24'(link.devBusOe), 24'h00_0000);
        check(24'({leftAudioOut, rightAudioOut}), 24'h00_0000);
        resetn = 1'b1;
        test_par_write();
        test_par_read();
        test_serial();
        test_rom();
        wrapUp();
    end
endmodule : voice_chip_host_and_rom_port_tb
